//--- sim/bju_props.sv
`timescale 1ns/1ps
module bju_props (
  input wire I_SYS_CLK, // Core clock
  input wire I_RST_N, // Sync reset, active low
  input wire [7:0] I_OPCODE, // Opcode
  input wire [3:0] I_FLAGS, // N V Z C
  input wire [7:0] I_SP, // Stack pointer
  input wire O_ACCEPT, // Start taken
  input wire O_BUSY, // Executing
  input wire O_DONE, // Result pulse
  input wire O_TAKEN, // Branch taken
  input wire [15:0] O_PC, // New PC
  input wire [7:0] O_SP, // New SP
  input wire O_Y_WE, // Y write pulse
  input wire O_MEM_RD, // Read strobe
  input wire O_MEM_WR // Write strobe
);
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RST_N);
  ////////////////////////////////////////////////////////////////////////////////
  // Every instruction lasts at least two cycles, so a second pulse in a row is a slip
  a_done_single: assert property (O_DONE |=> !O_DONE) else $error("done longer than one cycle");
  a_busy_ends: assert property ($fell(O_BUSY) |-> O_DONE) else $error("busy ended without done");
  a_busy_follows: assert property (O_ACCEPT |=> O_BUSY) else $error("no busy after accept");
  a_carry_short: assert property (O_ACCEPT && I_OPCODE == 8'h50 && I_FLAGS[0] |=> O_BUSY ##1
    (O_DONE && !O_TAKEN && !O_BUSY)) else $error("carry-low branch not two cycles");
  a_always_len: assert property (O_ACCEPT && I_OPCODE == 8'h2f |=> O_BUSY [*3] ##1 (O_DONE && O_TAKEN))
    else $error("unconditional branch not four cycles");
  a_jump_len: assert property (O_ACCEPT && I_OPCODE == 8'h1b |=> O_BUSY ##1 O_BUSY ##1
    (O_DONE && !O_TAKEN)) else $error("absolute jump not three cycles");
  a_call_stack: assert property (O_ACCEPT && I_OPCODE == 8'h3b |-> ##8
    (O_DONE && O_SP == $past(I_SP, 8) - 8'h02)) else $error("call length or stack wrong");
  a_page_high: assert property (O_ACCEPT && I_OPCODE == 8'h4f |-> ##6
    (O_DONE && O_PC[15:8] == 8'hff)) else $error("page call target wrong");
  a_table_push: assert property (O_ACCEPT && I_OPCODE[3:0] == 4'ha |=> O_MEM_WR ##1 O_MEM_WR)
    else $error("table call push missing");
  a_ywe_done: assert property (O_Y_WE |-> O_DONE) else $error("Y write outside done");
  a_strobe_excl: assert property (!(O_MEM_RD && O_MEM_WR)) else $error("read and write together");
endmodule // bju_props

bind cpu_branch_jump_unit bju_props u_props (.I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_OPCODE(I_OPCODE),
  .I_FLAGS(I_FLAGS), .I_SP(I_SP), .O_ACCEPT(O_ACCEPT), .O_BUSY(O_BUSY), .O_DONE(O_DONE), .O_TAKEN(O_TAKEN),
  .O_PC(O_PC), .O_SP(O_SP), .O_Y_WE(O_Y_WE), .O_MEM_RD(O_MEM_RD), .O_MEM_WR(O_MEM_WR));

//--- sim/cpu_branch_jump_unit_tb.sv
`timescale 1ns/1ps
module cpu_branch_jump_unit_tb;
`define CHK(a, b) begin checks = checks + 1; if ((a) !== (b)) begin err_total = err_total + 1; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
  reg I_SYS_CLK = 1'b0, I_RST_N = 1'b0, I_START = 1'b0;
  reg [7:0] I_OPCODE = 8'h00, I_SP = 8'hf0, I_A = 8'h20, I_X = 8'h01, I_Y = 8'h00, I_DP_HIGH = 8'h02;
  reg [15:0] I_PC = 16'h1000;
  reg [3:0] I_FLAGS = 4'h0;
  wire [7:0] I_MEM_RDATA, O_SP, O_Y, O_MEM_WDATA;
  wire [15:0] O_PC, O_MEM_ADDR;
  wire O_BUSY, O_ACCEPT, O_DONE, O_TAKEN, O_Y_WE, O_MEM_RD, O_MEM_WR;
  reg [7:0] mem [0:65535];
  integer checks = 0, err_total = 0;
  cpu_branch_jump_unit u_dut (.I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_START(I_START),
    .I_OPCODE(I_OPCODE), .I_PC(I_PC), .I_SP(I_SP), .I_A(I_A), .I_X(I_X), .I_Y(I_Y), .I_FLAGS(I_FLAGS),
    .I_DP_HIGH(I_DP_HIGH), .I_MEM_RDATA(I_MEM_RDATA), .O_BUSY(O_BUSY), .O_ACCEPT(O_ACCEPT), .O_DONE(O_DONE),
    .O_TAKEN(O_TAKEN), .O_PC(O_PC), .O_SP(O_SP), .O_Y(O_Y), .O_Y_WE(O_Y_WE), .O_MEM_ADDR(O_MEM_ADDR),
    .O_MEM_RD(O_MEM_RD), .O_MEM_WR(O_MEM_WR), .O_MEM_WDATA(O_MEM_WDATA));
  ////////////////////////////////////////////////////////////////////////////////
  // Memory answers only while read is strobed; otherwise it shows the inverse so stale use shows up
  assign I_MEM_RDATA = O_MEM_RD ? mem[O_MEM_ADDR] : ~mem[O_MEM_ADDR];
  always @(posedge I_SYS_CLK)
  begin
    if (O_MEM_WR)
      mem[O_MEM_ADDR] <= O_MEM_WDATA;
  end
  initial
  begin
    forever #4 I_SYS_CLK = ~I_SYS_CLK;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task wrap_up;
  begin
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  // One instruction: start, count cycles up to done, compare the results
  task run(input [7:0] op, input integer n, input [15:0] epc, input etk);
    integer k;
  begin
    @(negedge I_SYS_CLK);
    I_OPCODE = op;
    I_START = 1'b1;
    #1;
    `CHK(O_ACCEPT, 1'b1)
    @(negedge I_SYS_CLK);
    I_START = 1'b0;
    k = 1;
    while (O_DONE !== 1'b1 && k < 20)
    begin
      @(negedge I_SYS_CLK);
      k = k + 1;
    end
    `CHK(k, n)
    `CHK(O_PC, epc)
    `CHK(O_TAKEN, etk)
    `CHK(O_Y_WE, op == 8'h7b)
  end
  endtask
  task pushed(input [7:0] hi, input [7:0] lo);
  begin
    `CHK(mem[16'h01f0], hi)
    `CHK(mem[16'h01ef], lo)
    `CHK(O_SP, 8'hee)
    mem[16'h01f0] = 8'h00;
    mem[16'h01ef] = 8'h00;
  end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Other flags are set opposite to the tested one so a wrong flag choice shows
  task t_flags;
    reg [63:0] ops;
    reg [15:0] sel;
    reg [7:0] sense;
    reg [1:0] b;
    reg tk;
    integer i, v;
  begin
    ops = 64'hb030_1070_90f0_d050;
    sel = 16'hadd0;
    sense = 8'h8e;
    mem[16'h1000] = 8'hfe;
    for (i = 0; i < 8; i = i + 1)
      for (v = 0; v < 2; v = v + 1)
      begin
        b = sel[2 * i +: 2];
        tk = (v == sense[i]);
        I_FLAGS = (v == 1) ? (4'h1 << b) : ~(4'h1 << b);
        run(ops[8 * i +: 8], tk ? 4 : 2, tk ? 16'h0fff : 16'h1001, tk);
      end
    I_FLAGS = 4'h0;
    mem[16'h1000] = 8'h7f;
    run(8'h2f, 4, 16'h1080, 1'b1);
    $display("t_flags done");
  end
  endtask
  task t_bits;
    integer i;
    reg tk;
  begin
    I_A = 8'h20;
    mem[16'h1000] = 8'h10;
    for (i = 0; i < 16; i = i + 1)
    begin
      tk = (I_A[i / 2] != i[0]);
      run({i[3:0], 4'h2}, tk ? 6 : 4, tk ? 16'h1011 : 16'h1001, tk);
    end
    mem[16'h1000] = 8'h40;
    mem[16'h0240] = 8'h20;
    mem[16'h1001] = 8'h80;
    run(8'ha3, 7, 16'h0f82, 1'b1);
    run(8'hb3, 5, 16'h1002, 1'b0);
    $display("t_bits done");
  end
  endtask
  task t_cmp_dec;
  begin
    I_A = 8'h33;
    mem[16'h1000] = 8'h40;
    mem[16'h1001] = 8'h05;
    mem[16'h0240] = 8'h33;
    run(8'hfd, 5, 16'h1002, 1'b0);
    mem[16'h0240] = 8'h34;
    run(8'hfd, 7, 16'h1007, 1'b1);
    mem[16'h0241] = 8'h33;
    run(8'h8d, 6, 16'h1002, 1'b0);
    mem[16'h0241] = 8'h00;
    run(8'h8d, 8, 16'h1007, 1'b1);
    mem[16'h0240] = 8'h01;
    run(8'hac, 5, 16'h1002, 1'b0);
    `CHK(mem[16'h0240], 8'h00)
    run(8'hac, 7, 16'h1007, 1'b1);
    `CHK(mem[16'h0240], 8'hff)
    mem[16'h1000] = 8'h05;
    I_Y = 8'h01;
    run(8'h7b, 4, 16'h1001, 1'b0);
    `CHK(O_Y, 8'h00)
    I_Y = 8'h00;
    run(8'h7b, 6, 16'h1006, 1'b1);
    `CHK(O_Y, 8'hff)
    $display("t_cmp_dec done");
  end
  endtask
  task t_jumps;
  begin
    mem[16'h1000] = 8'h34;
    mem[16'h1001] = 8'h12;
    mem[16'h1234] = 8'h78;
    mem[16'h1235] = 8'h56;
    run(8'h1b, 3, 16'h1234, 1'b0);
    run(8'h1f, 5, 16'h5678, 1'b0);
    // Pointer at the page end wraps inside the direct page
    mem[16'h1000] = 8'hff;
    mem[16'h02ff] = 8'hcd;
    mem[16'h0200] = 8'hab;
    run(8'h3f, 4, 16'habcd, 1'b0);
    $display("t_jumps done");
  end
  endtask
  task t_calls;
    integer n;
  begin
    mem[16'h1000] = 8'h00;
    mem[16'h1001] = 8'h20;
    run(8'h3b, 8, 16'h2000, 1'b0);
    pushed(8'h10, 8'h02);
    mem[16'h1000] = 8'h40;
    mem[16'h0240] = 8'h00;
    mem[16'h0241] = 8'h30;
    run(8'h5f, 8, 16'h3000, 1'b0);
    pushed(8'h10, 8'h01);
    mem[16'h1000] = 8'h55;
    run(8'h4f, 6, 16'hff55, 1'b0);
    pushed(8'h10, 8'h01);
    for (n = 0; n < 16; n = n + 1)
    begin
      mem[16'hffc0 + {n[3:0], 1'b0}] = n[7:0];
      mem[16'hffc1 + {n[3:0], 1'b0}] = 8'h80;
      run({n[3:0], 4'ha}, 8, {8'h80, n[7:0]}, 1'b0);
      pushed(8'h10, 8'h00);
    end
    $display("t_calls done");
  end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge I_SYS_CLK);
    @(negedge I_SYS_CLK);
    `CHK(O_BUSY, 1'b0)
    `CHK(O_DONE, 1'b0)
    I_RST_N = 1'b1;
    t_flags;
    t_bits;
    t_cmp_dec;
    t_jumps;
    t_calls;
    wrap_up;
  end
  // Whole run is well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge I_SYS_CLK);
    err_total = err_total + 1;
    wrap_up;
  end
endmodule // cpu_branch_jump_unit_tb

//--- src/bju_cond.v
`timescale 1ns/1ps
`include "bju_regs.vh"

module bju_cond (
  input wire [3:0] i_cls, // Instruction class
  input wire [7:0] i_op, // Opcode
  input wire [3:0] i_flags, // N V Z C
  input wire [7:0] i_bit_src, // Byte holding the tested bit
  input wire [7:0] i_acc, // Accumulator
  input wire [7:0] i_val, // Memory byte or Y before decrement
  output reg o_taken // Branch condition holds
);

  wire fn = i_flags[3];
  wire fv = i_flags[2];
  wire fz = i_flags[1];
  wire fc = i_flags[0];
  wire bitv = i_bit_src[i_op[7:5]];

  always @*
  begin
    o_taken = 1'b0;
    case (i_cls)
      `CLS_BRF:
      begin
        case (i_op)
          `OP_BRANCH_CARRY_LOW: o_taken = ~fc;
          `OP_BRANCH_CARRY_HIGH: o_taken = fc;
          `OP_BRANCH_ZERO_SET: o_taken = fz;
          `OP_BRANCH_NEGATIVE: o_taken = fn;
          `OP_BRANCH_ZERO_CLEAR: o_taken = ~fz;
          `OP_BRANCH_POSITIVE: o_taken = ~fn;
          `OP_BRANCH_UNCONDITIONAL: o_taken = 1'b1;
          `OP_BRANCH_OVERFLOW_LOW: o_taken = ~fv;
          `OP_BRANCH_OVERFLOW_HIGH: o_taken = fv;
          default: o_taken = 1'b0;
        endcase
      end
      // Odd upper nibble tests for a clear bit, even for a set bit
      `CLS_BBA, `CLS_BBD: o_taken = i_op[4] ? ~bitv : bitv;
      `CLS_CBD, `CLS_CBX: o_taken = (i_acc != i_val);
      // Result after decrement is non-zero unless the old value was one
      `CLS_DBD, `CLS_DBY: o_taken = (i_val != 8'h01);
      default: o_taken = 1'b0;
    endcase
  end

endmodule // bju_cond

//--- src/bju_regs.vh
`ifndef BJU_REGS_VH
`define BJU_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// Instruction classes handled by the unit
`define CLS_NONE 4'h0
`define CLS_BRF 4'h1
`define CLS_BBA 4'h2
`define CLS_BBD 4'h3
`define CLS_CBD 4'h4
`define CLS_CBX 4'h5
`define CLS_DBD 4'h6
`define CLS_DBY 4'h7
`define CLS_JAB 4'h8
`define CLS_JIA 4'h9
`define CLS_JID 4'hA
`define CLS_CAB 4'hB
`define CLS_CID 4'hC
`define CLS_PCL 4'hD
`define CLS_TCL 4'hE

////////////////////////////////////////////////////////////////////////////////
// Opcodes
`define OP_BRANCH_CARRY_LOW 8'h50
`define OP_BRANCH_CARRY_HIGH 8'hD0
`define OP_BRANCH_ZERO_SET 8'hF0
`define OP_BRANCH_NEGATIVE 8'h90
`define OP_BRANCH_ZERO_CLEAR 8'h70
`define OP_BRANCH_POSITIVE 8'h10
`define OP_BRANCH_UNCONDITIONAL 8'h2F
`define OP_BRANCH_OVERFLOW_LOW 8'h30
`define OP_BRANCH_OVERFLOW_HIGH 8'hB0
`define OP_CALL_ABS 8'h3B
`define OP_CALL_IND 8'h5F
`define OP_CMP_BR_DP 8'hFD
`define OP_CMP_BR_DPX 8'h8D
`define OP_DEC_BR_DP 8'hAC
`define OP_DEC_BR_Y 8'h7B
`define OP_JUMP_ABS 8'h1B
`define OP_JUMP_ABS_IND 8'h1F
`define OP_JUMP_DP_IND 8'h3F
`define OP_PAGE_CALL 8'h4F
`define NIB_BIT_ACC 4'h2
`define NIB_BIT_DP 4'h3
`define NIB_TABLE_CALL 4'hA

////////////////////////////////////////////////////////////////////////////////
// Cycle counts, short (not taken) and long (taken or fixed)
`define CYC_BRF_S 4'h2
`define CYC_BRF_L 4'h4
`define CYC_BRA 4'h4
`define CYC_BBA_S 4'h4
`define CYC_BBA_L 4'h6
`define CYC_BBD_S 4'h5
`define CYC_BBD_L 4'h7
`define CYC_CBX_S 4'h6
`define CYC_CBX_L 4'h8
`define CYC_JAB 4'h3
`define CYC_JIA 4'h5
`define CYC_JID 4'h4
`define CYC_CALL 4'h8
`define CYC_PCL 4'h6

////////////////////////////////////////////////////////////////////////////////
// Address map pieces
`define PAGE_CALL_HI 8'hFF
`define STACK_HI 8'h01
`define TVEC_BASE 16'hFFC0

`endif

//--- src/cpu_branch_jump_unit.v
`timescale 1ns/1ps
`include "bju_regs.vh"

module cpu_branch_jump_unit (
  input wire I_SYS_CLK, // Core clock, 125 MHz
  input wire I_RST_N, // Synchronous reset, active low
  input wire I_START, // Opcode fetched, start executing
  input wire [7:0] I_OPCODE, // Opcode byte
  input wire [15:0] I_PC, // Address of the byte after the opcode
  input wire [7:0] I_SP, // Stack pointer at start
  input wire [7:0] I_A, // Accumulator
  input wire [7:0] I_X, // X register
  input wire [7:0] I_Y, // Y register
  input wire [3:0] I_FLAGS, // PSW flags N V Z C
  input wire [7:0] I_DP_HIGH, // High address byte of the direct page
  input wire [7:0] I_MEM_RDATA, // Read data, same cycle as address
  output wire O_BUSY, // Instruction in progress
  output wire O_ACCEPT, // Start taken this cycle
  output reg O_DONE, // Results valid, one cycle
  output reg O_TAKEN, // Branch was taken
  output reg [15:0] O_PC, // New program counter
  output reg [7:0] O_SP, // New stack pointer
  output reg [7:0] O_Y, // New Y register
  output reg O_Y_WE, // Y must be written, with O_DONE
  output reg [15:0] O_MEM_ADDR, // Memory address
  output reg O_MEM_RD, // Memory read strobe
  output reg O_MEM_WR, // Memory write strobe
  output reg [7:0] O_MEM_WDATA // Memory write data
);

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function [3:0] cls_of;
    input [7:0] op;
    begin
      case (op)
        `OP_BRANCH_CARRY_LOW, `OP_BRANCH_CARRY_HIGH, `OP_BRANCH_ZERO_SET,
        `OP_BRANCH_NEGATIVE, `OP_BRANCH_ZERO_CLEAR, `OP_BRANCH_POSITIVE,
        `OP_BRANCH_UNCONDITIONAL, `OP_BRANCH_OVERFLOW_LOW,
        `OP_BRANCH_OVERFLOW_HIGH: cls_of = `CLS_BRF;
        `OP_CMP_BR_DP: cls_of = `CLS_CBD;
        `OP_CMP_BR_DPX: cls_of = `CLS_CBX;
        `OP_DEC_BR_DP: cls_of = `CLS_DBD;
        `OP_DEC_BR_Y: cls_of = `CLS_DBY;
        `OP_JUMP_ABS: cls_of = `CLS_JAB;
        `OP_JUMP_ABS_IND: cls_of = `CLS_JIA;
        `OP_JUMP_DP_IND: cls_of = `CLS_JID;
        `OP_CALL_ABS: cls_of = `CLS_CAB;
        `OP_CALL_IND: cls_of = `CLS_CID;
        `OP_PAGE_CALL: cls_of = `CLS_PCL;
        default:
        begin
          case (op[3:0])
            `NIB_BIT_ACC: cls_of = `CLS_BBA;
            `NIB_BIT_DP: cls_of = `CLS_BBD;
            `NIB_TABLE_CALL: cls_of = `CLS_TCL;
            default: cls_of = `CLS_NONE;
          endcase
        end
      endcase
    end
  endfunction

  // Long count is assumed at start and cut back once a branch is seen to fail
  function [3:0] cyc_long;
    input [3:0] cls;
    begin
      case (cls)
        `CLS_BRF: cyc_long = `CYC_BRF_L;
        `CLS_BBA, `CLS_DBY: cyc_long = `CYC_BBA_L;
        `CLS_BBD, `CLS_CBD, `CLS_DBD: cyc_long = `CYC_BBD_L;
        `CLS_CBX: cyc_long = `CYC_CBX_L;
        `CLS_JAB: cyc_long = `CYC_JAB;
        `CLS_JIA: cyc_long = `CYC_JIA;
        `CLS_JID: cyc_long = `CYC_JID;
        `CLS_PCL: cyc_long = `CYC_PCL;
        default: cyc_long = `CYC_CALL;
      endcase
    end
  endfunction

  function [3:0] cyc_short;
    input [3:0] cls;
    input [7:0] op;
    begin
      case (cls)
        `CLS_BRF: cyc_short = (op == `OP_BRANCH_UNCONDITIONAL) ? `CYC_BRA : `CYC_BRF_S;
        `CLS_BBA, `CLS_DBY: cyc_short = `CYC_BBA_S;
        `CLS_CBX: cyc_short = `CYC_CBX_S;
        default: cyc_short = `CYC_BBD_S;
      endcase
    end
  endfunction

  // Signed displacement from the byte after the instruction
  function [15:0] rel_target;
    input [15:0] after;
    input [7:0] rel;
    begin
      rel_target = after + {{8{rel[7]}}, rel};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State

  reg busy_q, busy_d;
  reg done_d, taken_d, ywe_d;
  reg [7:0] op_q, op_d;
  reg [3:0] cls_q, cls_d;
  reg [3:0] cnt_q, cnt_d;
  reg [3:0] tot_q, tot_d;
  reg [15:0] fp_q, fp_d;
  reg [7:0] sp_d;
  reg [7:0] val_q, val_d;
  reg [7:0] lo_q, lo_d;
  reg [15:0] ea_q, ea_d;
  reg [15:0] tgt_d;
  reg [7:0] y_d;
  reg [7:0] a_q, a_d;
  reg [7:0] x_q, x_d;
  reg [3:0] flg_q, flg_d;
  reg [7:0] dph_q, dph_d;
  reg [15:0] addr_d;
  reg rd_d, wr_d;
  reg [7:0] wd_d;
  reg decide, push;
  reg [15:0] after;
  reg [7:0] push_byte;
  reg [15:0] ret_pc;

  wire [3:0] start_cls = cls_of(I_OPCODE);
  wire cond_taken;
  wire [7:0] bit_src = (cls_q == `CLS_BBA) ? a_q : val_q;
  wire [7:0] cmp_val = (cls_q == `CLS_DBY) ? O_Y : val_q;

  assign O_BUSY = busy_q;
  // Unknown opcodes are not accepted and leave all outputs alone
  assign O_ACCEPT = I_START & ~busy_q & (start_cls != `CLS_NONE);

  bju_cond u_cond (
    .i_cls(cls_q),
    .i_op(op_q),
    .i_flags(flg_q),
    .i_bit_src(bit_src),
    .i_acc(a_q),
    .i_val(cmp_val),
    .o_taken(cond_taken)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer: cycle 0 is the start cycle, busy cycles count from 1

  always @*
  begin
    busy_d = busy_q;
    op_d = op_q;
    cls_d = cls_q;
    cnt_d = cnt_q;
    tot_d = tot_q;
    fp_d = fp_q;
    sp_d = O_SP;
    val_d = val_q;
    lo_d = lo_q;
    ea_d = ea_q;
    tgt_d = O_PC;
    y_d = O_Y;
    a_d = a_q;
    x_d = x_q;
    flg_d = flg_q;
    dph_d = dph_q;
    addr_d = O_MEM_ADDR;
    wd_d = O_MEM_WDATA;
    rd_d = 1'b0;
    wr_d = 1'b0;
    done_d = 1'b0;
    ywe_d = 1'b0;
    taken_d = O_TAKEN;
    decide = 1'b0;
    push = 1'b0;
    push_byte = 8'h00;
    after = fp_q + 16'h0001;
    // Return address points past the whole instruction
    case (cls_q)
      `CLS_CAB: ret_pc = fp_q + 16'h0002;
      `CLS_TCL: ret_pc = fp_q;
      default: ret_pc = fp_q + 16'h0001;
    endcase
    if (!busy_q)
    begin
      if (O_ACCEPT)
      begin
        busy_d = 1'b1;
        op_d = I_OPCODE;
        cls_d = start_cls;
        cnt_d = 4'h1;
        tot_d = cyc_long(start_cls);
        fp_d = I_PC;
        sp_d = I_SP;
        y_d = I_Y;
        a_d = I_A;
        x_d = I_X;
        flg_d = I_FLAGS;
        dph_d = I_DP_HIGH;
        tgt_d = I_PC;
        taken_d = 1'b0;
        ea_d = `TVEC_BASE + {11'h000, I_OPCODE[7:4], 1'b0};
        if (start_cls == `CLS_TCL)
        begin
          addr_d = {`STACK_HI, I_SP};
          wd_d = I_PC[15:8];
          wr_d = 1'b1;
          sp_d = I_SP - 8'h01;
        end
        else
        begin
          addr_d = I_PC;
          rd_d = 1'b1;
        end
      end
    end
    else
    begin
      cnt_d = cnt_q + 4'h1;
      case (cls_q)
        `CLS_BRF, `CLS_BBA:
        begin
          if (cnt_q == 4'h1)
            decide = 1'b1;
        end
        `CLS_DBY:
        begin
          if (cnt_q == 4'h1)
          begin
            decide = 1'b1;
            y_d = O_Y - 8'h01;
          end
        end
        `CLS_BBD, `CLS_CBD, `CLS_CBX:
        begin
          if (cnt_q == 4'h1)
          begin
            rd_d = 1'b1;
            addr_d = {dph_q, I_MEM_RDATA + ((cls_q == `CLS_CBX) ? x_q : 8'h00)};
          end
          else if (cnt_q == 4'h2)
          begin
            val_d = I_MEM_RDATA;
            rd_d = 1'b1;
            addr_d = fp_q + 16'h0001;
          end
          else if (cnt_q == 4'h3)
          begin
            decide = 1'b1;
            after = fp_q + 16'h0002;
          end
        end
        `CLS_DBD:
        begin
          if (cnt_q == 4'h1)
          begin
            rd_d = 1'b1;
            addr_d = {dph_q, I_MEM_RDATA};
            ea_d = {dph_q, I_MEM_RDATA};
          end
          else if (cnt_q == 4'h2)
          begin
            val_d = I_MEM_RDATA;
            wr_d = 1'b1;
            addr_d = ea_q;
            wd_d = I_MEM_RDATA - 8'h01;
          end
          else if (cnt_q == 4'h3)
          begin
            rd_d = 1'b1;
            addr_d = fp_q + 16'h0001;
          end
          else if (cnt_q == 4'h4)
          begin
            decide = 1'b1;
            after = fp_q + 16'h0002;
          end
        end
        `CLS_JAB, `CLS_JIA, `CLS_CAB:
        begin
          if (cnt_q == 4'h1)
          begin
            lo_d = I_MEM_RDATA;
            rd_d = 1'b1;
            addr_d = fp_q + 16'h0001;
          end
          else if (cnt_q == 4'h2)
          begin
            if (cls_q == `CLS_JIA)
            begin
              rd_d = 1'b1;
              addr_d = {I_MEM_RDATA, lo_q};
              ea_d = {I_MEM_RDATA, lo_q};
            end
            else
              tgt_d = {I_MEM_RDATA, lo_q};
            if (cls_q == `CLS_CAB)
            begin
              push = 1'b1;
              push_byte = ret_pc[15:8];
            end
          end
          else if (cnt_q == 4'h3)
          begin
            if (cls_q == `CLS_JIA)
            begin
              lo_d = I_MEM_RDATA;
              rd_d = 1'b1;
              addr_d = ea_q + 16'h0001;
            end
            else
            begin
              push = 1'b1;
              push_byte = ret_pc[7:0];
            end
          end
          else if (cnt_q == 4'h4 && cls_q == `CLS_JIA)
            tgt_d = {I_MEM_RDATA, lo_q};
        end
        `CLS_JID, `CLS_CID:
        begin
          if (cnt_q == 4'h1)
          begin
            rd_d = 1'b1;
            addr_d = {dph_q, I_MEM_RDATA};
            ea_d = {dph_q, I_MEM_RDATA};
          end
          else if (cnt_q == 4'h2)
          begin
            lo_d = I_MEM_RDATA;
            rd_d = 1'b1;
            // Pointer high byte stays inside the direct page
            addr_d = {dph_q, ea_q[7:0] + 8'h01};
          end
          else if (cnt_q == 4'h3)
          begin
            tgt_d = {I_MEM_RDATA, lo_q};
            if (cls_q == `CLS_CID)
            begin
              push = 1'b1;
              push_byte = ret_pc[15:8];
            end
          end
          else if (cnt_q == 4'h4 && cls_q == `CLS_CID)
          begin
            push = 1'b1;
            push_byte = ret_pc[7:0];
          end
        end
        `CLS_PCL:
        begin
          if (cnt_q == 4'h1)
          begin
            tgt_d = {`PAGE_CALL_HI, I_MEM_RDATA};
            push = 1'b1;
            push_byte = ret_pc[15:8];
          end
          else if (cnt_q == 4'h2)
          begin
            push = 1'b1;
            push_byte = ret_pc[7:0];
          end
        end
        `CLS_TCL:
        begin
          if (cnt_q == 4'h1)
          begin
            push = 1'b1;
            push_byte = ret_pc[7:0];
          end
          else if (cnt_q == 4'h2)
          begin
            rd_d = 1'b1;
            addr_d = ea_q;
          end
          else if (cnt_q == 4'h3)
          begin
            lo_d = I_MEM_RDATA;
            rd_d = 1'b1;
            addr_d = ea_q + 16'h0001;
          end
          else if (cnt_q == 4'h4)
            tgt_d = {I_MEM_RDATA, lo_q};
        end
        default: busy_d = 1'b0;
      endcase
      // Stack grows downward: write at SP, then decrement
      if (push)
      begin
        wr_d = 1'b1;
        addr_d = {`STACK_HI, O_SP};
        wd_d = push_byte;
        sp_d = O_SP - 8'h01;
      end
      // Displacement byte is on the bus in the deciding cycle
      if (decide)
      begin
        taken_d = cond_taken;
        tgt_d = cond_taken ? rel_target(after, I_MEM_RDATA) : after;
        tot_d = cond_taken ? tot_q : cyc_short(cls_q, op_q);
      end
      if (cnt_q == tot_d - 4'h1)
      begin
        busy_d = 1'b0;
        done_d = 1'b1;
        ywe_d = (cls_q == `CLS_DBY);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  always @(posedge I_SYS_CLK)
  begin
    if (!I_RST_N)
    begin
      busy_q <= 1'b0;
      op_q <= 8'h00;
      cls_q <= `CLS_NONE;
      cnt_q <= 4'h0;
      tot_q <= 4'h0;
      fp_q <= 16'h0000;
      val_q <= 8'h00;
      lo_q <= 8'h00;
      ea_q <= 16'h0000;
      a_q <= 8'h00;
      x_q <= 8'h00;
      flg_q <= 4'h0;
      dph_q <= 8'h00;
      O_DONE <= 1'b0;
      O_TAKEN <= 1'b0;
      O_PC <= 16'h0000;
      O_SP <= 8'h00;
      O_Y <= 8'h00;
      O_Y_WE <= 1'b0;
      O_MEM_ADDR <= 16'h0000;
      O_MEM_RD <= 1'b0;
      O_MEM_WR <= 1'b0;
      O_MEM_WDATA <= 8'h00;
    end
    else
    begin
      busy_q <= busy_d;
      op_q <= op_d;
      cls_q <= cls_d;
      cnt_q <= cnt_d;
      tot_q <= tot_d;
      fp_q <= fp_d;
      val_q <= val_d;
      lo_q <= lo_d;
      ea_q <= ea_d;
      a_q <= a_d;
      x_q <= x_d;
      flg_q <= flg_d;
      dph_q <= dph_d;
      O_DONE <= done_d;
      O_TAKEN <= taken_d;
      O_PC <= tgt_d;
      O_SP <= sp_d;
      O_Y <= y_d;
      O_Y_WE <= ywe_d;
      O_MEM_ADDR <= addr_d;
      O_MEM_RD <= rd_d;
      O_MEM_WR <= wr_d;
      O_MEM_WDATA <= wd_d;
    end
  end

endmodule // cpu_branch_jump_unit
